/* File: pcm_codec_pkg.sv */
// constants shared by the pcm codec digital interface and its control shifter
// assumes a single system clock; all pins arrive unsynchronised
package pcm_codec_pkg;

  // ==========================================================
  // pcm slot timing
  localparam int          SLOT_BITS      = 8;
  localparam logic [3:0]  SLOT_BITS_CNT  = 4'h8;

  // ==========================================================
  // control instruction byte layout
  localparam int          INSTR_PWR_BIT  = 7;
  localparam int          INSTR_ADDR_LSB = 4;
  localparam int          INSTR_RD_BIT   = 0;
  localparam logic [2:0]  CTL_LAST_BIT   = 3'h7;

  // ==========================================================
  // register addresses carried in the instruction byte
  localparam logic [2:0]  ADDR_MODE      = 3'h0;
  localparam logic [2:0]  ADDR_TX_SLOT   = 3'h1;
  localparam logic [2:0]  ADDR_RX_SLOT   = 3'h2;
  localparam logic [2:0]  ADDR_LATCH_DIR = 3'h3;
  localparam logic [2:0]  ADDR_LATCH_VAL = 3'h4;

  // ==========================================================
  // mode register fields and reset values
  localparam int          MODE_DELAYED   = 0;
  localparam int          MODE_TX_PORT   = 1;
  localparam int          MODE_RX_PORT   = 2;
  localparam logic [2:0]  RST_MODE       = 3'h0;
  localparam logic        RST_PDOWN      = 1'b1;

  // ==========================================================
  // control shifter states
  typedef enum logic [2:0] {
    ST_INSTR = 3'b001,
    ST_DATA  = 3'b010,
    ST_IDLE  = 3'b100
  } ctl_state_e;

endpackage

/* File: ctl_if.sv */
// control shifter to register file link
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ctl_if;
  logic       instr_done;
  logic       wr_done;
  logic [7:0] instr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport shifter (output instr_done, output wr_done, output instr, output wdata, input rdata);
  modport regs    (input instr_done, input wr_done, input instr, input wdata, output rdata);
endinterface

/* File: ctl_shifter.sv */
// serial control port: instruction byte then data byte, msb first
// assumes the control clock is far slower than the system clock
`timescale 1ns/1ps
module ctl_shifter
  import pcm_codec_pkg::*;
(
  // system
  input  wire logic clock,
  input  wire logic rst,
  // pins
  input  wire logic sclk_raw,
  input  wire logic cs_n_raw,
  input  wire logic din_raw,
  output logic      dout,
  output logic      dout_en,
  // register side
  ctl_if.shifter    bus
);

  // ==========================================================
  // synchronisers and edge detection
  logic [2:0] sclk_s_q;
  logic [2:0] cs_s_q;
  logic [1:0] din_s_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      // control clock idles high; a low reset value would fake a rise
      sclk_s_q <= 3'h7;
      cs_s_q   <= 3'h7;
      din_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_raw};
      cs_s_q   <= {cs_s_q[1:0], cs_n_raw};
      din_s_q  <= {din_s_q[0], din_raw};
    end
  end

  wire selected = ~cs_s_q[1];
  wire cs_fall  = ~cs_s_q[1] & cs_s_q[2];
  wire sample   = selected & ~sclk_s_q[1] & sclk_s_q[2];
  wire launch   = selected & sclk_s_q[1] & ~sclk_s_q[2];

  // ==========================================================
  // shift state
  ctl_state_e state_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] out_q;
  logic [7:0] instr_q;
  logic [7:0] wdata_q;
  logic       instr_done_q;
  logic       wr_done_q;

  wire        last_bit = (cnt_q == CTL_LAST_BIT);
  wire [7:0]  sh_next  = {sh_q[6:0], din_s_q[1]};
  wire        reading  = instr_q[INSTR_RD_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q      <= ST_INSTR;
      cnt_q        <= 3'h0;
      sh_q         <= 8'h00;
      out_q        <= 8'h00;
      instr_q      <= 8'h00;
      wdata_q      <= 8'h00;
      instr_done_q <= 1'b0;
      wr_done_q    <= 1'b0;
    end else begin
      instr_done_q <= 1'b0;
      wr_done_q    <= 1'b0;
      if (cs_fall) begin
        state_q <= ST_INSTR;
        cnt_q   <= 3'h0;
      end else if (sample) begin
        case (state_q)
          ST_INSTR: begin
            sh_q  <= sh_next;
            cnt_q <= cnt_q + 3'h1;
            if (last_bit) begin
              instr_q      <= sh_next;
              instr_done_q <= 1'b1;
              state_q      <= ST_DATA;
            end
          end
          ST_DATA: begin
            sh_q  <= sh_next;
            cnt_q <= cnt_q + 3'h1;
            if (last_bit) begin
              wdata_q   <= sh_next;
              wr_done_q <= ~reading;
              state_q   <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      // out bits change on rising control clock edges
      if (launch && state_q == ST_DATA && reading) begin
        out_q <= (cnt_q == 3'h0) ? bus.rdata : {out_q[6:0], 1'b0};
      end
    end
  end

  // drive only for a read data byte
  // a read cut short leaves ST_DATA behind; keep off until the reselect resets it
  assign dout_en        = selected & ~cs_fall & (state_q == ST_DATA) & reading;
  assign dout           = out_q[7];
  assign bus.instr_done = instr_done_q;
  assign bus.wr_done    = wr_done_q;
  assign bus.instr      = instr_q;
  assign bus.wdata      = wdata_q;

  // ==========================================================
  // checks
  property p_desel_quiet;
    @(posedge clock) disable iff (rst)
      cs_s_q[1] && cs_s_q[2] |=> !dout_en && $stable(cnt_q) && $stable(sh_q);
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("shifter moved while deselected");

  sequence s_byte_in;
    sample && last_bit && state_q == ST_INSTR;
  endsequence
  property p_instr_commit;
    @(posedge clock) disable iff (rst)
      s_byte_in |=> instr_done_q && state_q == ST_DATA && instr_q == $past(sh_next);
  endproperty
  a_instr_commit: assert property (p_instr_commit) else $error("instruction byte not taken");

endmodule

/* File: pcm_codec_digital_interface.sv */
// pcm codec digital interface: serial pcm port, latch pins, control port
// assumes every pin is asynchronous to clock; bit and control clocks are
// at least four system clocks per half period
// Contract
// - transmit outputs float outside assigned slot
// - transmit bits change on bit clock rise
// - slot indicator pulls low during slot
// - receive inputs ignored outside assigned slot
// - receive bits sampled on bit clock fall
// - latch direction register sets pin direction
// - input latch levels captured on every control instruction byte, read or write
// - output latch pins follow written value
// - control bits shift only while selected
// - control clock crosses safely into system clock
// - bidirectional control pin direction from instruction
// - exactly eight bits per pcm slot
// - reset: latches inputs, non-delayed, powered down
// - master reset pulse restores initial state
// - power-down floats transmit, keeps control alive
`timescale 1ns/1ps
module pcm_codec_digital_interface
  import pcm_codec_pkg::*;
#(
  parameter int   NLATCH     = 6,
  parameter int   SLOT_W     = 6,
  parameter logic BIDIR_CTRL = 1'b0
) (
  // system
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              master_reset_in,
  // pcm pins
  input  wire logic              bit_clock,
  input  wire logic              tx_frame_sync,
  input  wire logic              rx_frame_sync,
  input  wire logic              rx_pcm_in_a,
  input  wire logic              rx_pcm_in_b,
  output logic                   tx_pcm_out_a,
  output logic                   tx_pcm_out_a_oe,
  output logic                   tx_pcm_out_b,
  output logic                   tx_pcm_out_b_oe,
  output logic                   tx_slot_active_n_a,
  output logic                   tx_slot_active_n_a_oe,
  output logic                   tx_slot_active_n_b,
  output logic                   tx_slot_active_n_b_oe,
  // coder side
  input  wire logic [7:0]        tx_pcm_word,
  output logic                   tx_word_load,
  output logic [7:0]             rx_pcm_word,
  output logic                   rx_word_valid,
  output logic                   powered_down,
  // control pins
  input  wire logic              control_shift_clock,
  input  wire logic              chip_select_n,
  input  wire logic              control_serial_in,
  output logic                   control_serial_out,
  output logic                   control_serial_out_oe,
  input  wire logic              control_serial_bidir_i,
  output logic                   control_serial_bidir_o,
  output logic                   control_serial_bidir_oe,
  // latch pins
  input  wire logic [NLATCH-1:0] line_latch_i,
  output logic      [NLATCH-1:0] line_latch_o,
  output logic      [NLATCH-1:0] line_latch_oe
);

  localparam int CNT_W = SLOT_W + 4;

  // ==========================================================
  // reset and pin synchronisers
  logic [1:0] mr_s_q;
  logic [2:0] bclk_s_q;
  logic [1:0] fsx_s_q;
  logic [1:0] fsr_s_q;
  logic [1:0] dra_s_q;
  logic [1:0] drb_s_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      mr_s_q <= 2'h0;
    end else begin
      mr_s_q <= {mr_s_q[0], master_reset_in};
    end
  end

  // master reset joins the system reset
  wire irst = rst | mr_s_q[1];

  always_ff @(posedge clock) begin
    if (irst) begin
      bclk_s_q <= 3'h0;
      fsx_s_q  <= 2'h0;
      fsr_s_q  <= 2'h0;
      dra_s_q  <= 2'h0;
      drb_s_q  <= 2'h0;
    end else begin
      bclk_s_q <= {bclk_s_q[1:0], bit_clock};
      fsx_s_q  <= {fsx_s_q[0], tx_frame_sync};
      fsr_s_q  <= {fsr_s_q[0], rx_frame_sync};
      dra_s_q  <= {dra_s_q[0], rx_pcm_in_a};
      drb_s_q  <= {drb_s_q[0], rx_pcm_in_b};
    end
  end

  wire bclk_rise = bclk_s_q[1] & ~bclk_s_q[2];
  wire bclk_fall = ~bclk_s_q[1] & bclk_s_q[2];

  // ==========================================================
  // control port and registers
  ctl_if ctl ();
  logic              ctl_dout;
  logic              ctl_dout_en;
  logic [2:0]        mode_q;
  logic [SLOT_W-1:0] tx_slot_q;
  logic [SLOT_W-1:0] rx_slot_q;
  logic [NLATCH-1:0] dir_q;
  logic [NLATCH-1:0] val_q;
  logic [NLATCH-1:0] val_d;
  logic [NLATCH-1:0] latch_s1_q;
  logic [NLATCH-1:0] latch_s2_q;
  logic              pdown_q;

  ctl_shifter u_ctl (
    .clock    (clock),
    .rst      (irst),
    .sclk_raw (control_shift_clock),
    .cs_n_raw (chip_select_n),
    .din_raw  (BIDIR_CTRL ? control_serial_bidir_i : control_serial_in),
    .dout     (ctl_dout),
    .dout_en  (ctl_dout_en),
    .bus      (ctl.shifter)
  );

  // one pin or two, chosen by strap parameter
  assign control_serial_out      = ctl_dout;
  assign control_serial_out_oe   = ~BIDIR_CTRL & ctl_dout_en;
  assign control_serial_bidir_o  = ctl_dout;
  assign control_serial_bidir_oe = BIDIR_CTRL & ctl_dout_en;

  wire [2:0] addr     = ctl.instr[INSTR_ADDR_LSB +: 3];
  wire       wr_mode  = ctl.wr_done & (addr == ADDR_MODE);
  wire       wr_txs   = ctl.wr_done & (addr == ADDR_TX_SLOT);
  wire       wr_rxs   = ctl.wr_done & (addr == ADDR_RX_SLOT);
  wire       wr_dir   = ctl.wr_done & (addr == ADDR_LATCH_DIR);
  wire       wr_val   = ctl.wr_done & (addr == ADDR_LATCH_VAL);

  // register width must stay below eight bits for the zero padding
  assign ctl.rdata = (addr == ADDR_MODE)      ? {5'h00, mode_q} :
                     (addr == ADDR_TX_SLOT)   ? {{(8-SLOT_W){1'b0}}, tx_slot_q} :
                     (addr == ADDR_RX_SLOT)   ? {{(8-SLOT_W){1'b0}}, rx_slot_q} :
                     (addr == ADDR_LATCH_DIR) ? {{(8-NLATCH){1'b0}}, dir_q} :
                     (addr == ADDR_LATCH_VAL) ? {{(8-NLATCH){1'b0}}, val_q} : 8'h00;

  // reset state: inputs, non-delayed, powered down
  always_ff @(posedge clock) begin
    if (irst) begin
      mode_q    <= RST_MODE;
      tx_slot_q <= '0;
      rx_slot_q <= '0;
      dir_q     <= '0;
      pdown_q   <= RST_PDOWN;
    end else begin
      if (wr_mode) mode_q <= ctl.wdata[2:0];
      if (wr_txs) tx_slot_q <= ctl.wdata[SLOT_W-1:0];
      if (wr_rxs) rx_slot_q <= ctl.wdata[SLOT_W-1:0];
      if (wr_dir) dir_q <= ctl.wdata[NLATCH-1:0];
      if (ctl.instr_done) pdown_q <= ctl.instr[INSTR_PWR_BIT];
    end
  end

  // ==========================================================
  // latch pins
  for (genvar i = 0; i < NLATCH; i++) begin : g_latch
    // inputs captured when an instruction arrives
    assign val_d[i] = wr_val ? ctl.wdata[i] :
                      (ctl.instr_done & ~dir_q[i]) ? latch_s2_q[i] : val_q[i];
    always_ff @(posedge clock) begin
      if (irst) begin
        latch_s1_q[i] <= 1'b0;
        latch_s2_q[i] <= 1'b0;
        val_q[i]      <= 1'b0;
      end else begin
        latch_s1_q[i] <= line_latch_i[i];
        latch_s2_q[i] <= latch_s1_q[i];
        val_q[i]      <= val_d[i];
      end
    end
  end

  // output pins follow the value register
  assign line_latch_o  = val_q;
  assign line_latch_oe = dir_q;
  assign powered_down  = pdown_q;

  // ==========================================================
  // slot location, shared by both directions
  function automatic logic slot_hit(input logic fstart, input logic delayed,
                                    input logic [CNT_W-1:0] cnt, input logic [SLOT_W-1:0] slot);
    logic [CNT_W-1:0] pos;
    pos = {1'b0, slot, 3'h0} + {{(CNT_W-1){1'b0}}, 1'b1};
    slot_hit = delayed ? (cnt == pos) : fstart;
  endfunction

  logic             fsx_last_q;
  logic             fsr_last_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [CNT_W-1:0] rx_cnt_q;
  wire              tx_fstart = fsx_s_q[1] & ~fsx_last_q;
  wire              rx_fstart = fsr_s_q[1] & ~fsr_last_q;
  wire [CNT_W-1:0]  tx_cnt_now = tx_fstart ? '0 : ((&tx_cnt_q) ? tx_cnt_q : tx_cnt_q + 1'b1);
  wire [CNT_W-1:0]  rx_cnt_now = rx_fstart ? '0 : ((&rx_cnt_q) ? rx_cnt_q : rx_cnt_q + 1'b1);
  wire              tx_start  = bclk_rise & ~pdown_q &
                                slot_hit(tx_fstart, mode_q[MODE_DELAYED], tx_cnt_now, tx_slot_q);
  wire              rx_start  = bclk_rise & ~pdown_q &
                                slot_hit(rx_fstart, mode_q[MODE_DELAYED], rx_cnt_now, rx_slot_q);

  always_ff @(posedge clock) begin
    if (irst) begin
      fsx_last_q <= 1'b0;
      fsr_last_q <= 1'b0;
      tx_cnt_q   <= '1;
      rx_cnt_q   <= '1;
    end else if (bclk_rise) begin
      fsx_last_q <= fsx_s_q[1];
      fsr_last_q <= fsr_s_q[1];
      tx_cnt_q   <= tx_cnt_now;
      rx_cnt_q   <= rx_cnt_now;
    end
  end

  // ==========================================================
  // transmit shifter
  logic [7:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic       tx_port_q;
  wire        tx_drive = (tx_left_q != 4'h0);

  always_ff @(posedge clock) begin
    if (irst) begin
      tx_sh_q   <= 8'h00;
      tx_left_q <= 4'h0;
      tx_port_q <= 1'b0;
    end else if (pdown_q) begin
      // power-down abandons any slot in flight
      tx_left_q <= 4'h0;
    end else if (tx_start) begin
      tx_sh_q   <= tx_pcm_word;
      tx_left_q <= SLOT_BITS_CNT;
      tx_port_q <= mode_q[MODE_TX_PORT];
    end else if (bclk_rise && tx_drive) begin
      tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
      tx_left_q <= tx_left_q - 4'h1;
    end
  end

  // drive only selected port in slot
  assign tx_pcm_out_a          = tx_sh_q[7];
  assign tx_pcm_out_b          = tx_sh_q[7];
  assign tx_pcm_out_a_oe       = tx_drive & ~tx_port_q;
  assign tx_pcm_out_b_oe       = tx_drive & tx_port_q;
  assign tx_slot_active_n_a    = 1'b0;
  assign tx_slot_active_n_b    = 1'b0;
  assign tx_slot_active_n_a_oe = tx_pcm_out_a_oe;
  assign tx_slot_active_n_b_oe = tx_pcm_out_b_oe;
  assign tx_word_load          = tx_start;

  // ==========================================================
  // receive shifter
  logic [7:0] rx_sh_q;
  logic [3:0] rx_left_q;
  logic       rx_port_q;
  logic [7:0] rx_word_q;
  logic       rx_valid_q;
  wire        rx_bit  = rx_port_q ? drb_s_q[1] : dra_s_q[1];
  wire  [7:0] rx_next = {rx_sh_q[6:0], rx_bit};

  always_ff @(posedge clock) begin
    if (irst) begin
      rx_sh_q    <= 8'h00;
      rx_left_q  <= 4'h0;
      rx_port_q  <= 1'b0;
      rx_word_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (rx_start) begin
        rx_left_q <= SLOT_BITS_CNT;
        rx_port_q <= mode_q[MODE_RX_PORT];
      // sample on falls only inside slot
      end else if (bclk_fall && rx_left_q != 4'h0) begin
        rx_sh_q   <= rx_next;
        rx_left_q <= rx_left_q - 4'h1;
        if (rx_left_q == 4'h1) begin
          rx_word_q  <= rx_next;
          rx_valid_q <= 1'b1;
        end
      end
    end
  end

  assign rx_pcm_word   = rx_word_q;
  assign rx_word_valid = rx_valid_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (irst);

  property p_tx_float;
    !tx_drive |-> !tx_pcm_out_a_oe && !tx_pcm_out_b_oe && !tx_slot_active_n_a_oe;
  endproperty
  a_tx_float: assert property (p_tx_float) else $error("transmit driven outside slot");

  property p_tx_edge;
    $changed(tx_sh_q) |-> $past(bclk_rise);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("transmit bit moved off a rise");

  property p_ind_pair;
    tx_pcm_out_b_oe |-> tx_slot_active_n_b_oe && !tx_slot_active_n_b && !tx_pcm_out_a_oe;
  endproperty
  a_ind_pair: assert property (p_ind_pair) else $error("slot indicator out of step");

  property p_rx_ignore;
    $changed(rx_sh_q) |-> $past(bclk_fall) && $past(rx_left_q) != 4'h0;
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) else $error("receive bit taken outside slot");

  property p_dir_write;
    wr_dir |=> line_latch_oe == $past(ctl.wdata[NLATCH-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_capture;
    ctl.instr_done && !wr_val |=> ((val_q ^ $past(latch_s2_q)) & ~dir_q) == '0;
  endproperty
  a_capture: assert property (p_capture) else $error("input latch not captured");

  property p_out_val;
    wr_val |=> line_latch_o == $past(ctl.wdata[NLATCH-1:0]);
  endproperty
  a_out_val: assert property (p_out_val) else $error("latch output not updated");

  sequence s_tx_begin;
    tx_start && !pdown_q;
  endsequence
  property p_eight_bits;
    s_tx_begin |=> tx_left_q == SLOT_BITS_CNT && tx_sh_q == $past(tx_pcm_word);
  endproperty
  a_eight_bits: assert property (p_eight_bits) else $error("slot did not load eight bits");

  property p_pdown;
    pdown_q |=> !tx_pcm_out_a_oe && !tx_pcm_out_b_oe;
  endproperty
  a_pdown: assert property (p_pdown) else $error("transmit driven in power-down");

endmodule

/* File: tdm_host_model.sv */
// backplane model: bit clock, frame sync, receive bytes, transmit capture
// assumes one codec on the highway; frame sync only while arm is high
`timescale 1ns/1ps
module tdm_host_model #(
  parameter int FRAME_BITS = 156
) (
  // stimulus
  input  wire logic       arm,
  input  wire logic [7:0] rx_byte,
  input  wire logic [7:0] start,
  input  wire logic       rx_sel_b,
  // pins
  output logic            bit_clock,
  output logic            frame_sync,
  output logic            rx_a,
  output logic            rx_b,
  input  wire logic       tx_a,
  input  wire logic       tx_a_oe,
  input  wire logic       tx_b,
  input  wire logic       tx_b_oe,
  // capture
  output logic [7:0]      tx_byte,
  output int              tx_bits,
  output int              tx_cnt
);
  int         cnt = 0;
  int         j;
  int         n = 0;
  logic [7:0] sh = 8'h00;
  // ===
  // bit clock free running, phase unrelated to clock
  initial begin
    bit_clock = 0;
    frame_sync = 0;
    rx_a = 0;
    rx_b = 1;
    tx_byte = 0;
    tx_bits = 0;
    tx_cnt = 0;
    #137;
    forever #400 bit_clock = ~bit_clock;
  end
  always @(negedge bit_clock) frame_sync <= arm && cnt == FRAME_BITS - 1;
  always @(posedge bit_clock) begin
    cnt = (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    j = cnt - start;
    rx_a <= (j >= 0 && j < 8 && !rx_sel_b) ? rx_byte[7-j] : ~rx_a;
    rx_b <= (j >= 0 && j < 8 && rx_sel_b) ? rx_byte[7-j] : ~rx_b;
  end
  // sample late in the bit: output settles a few clocks after the rise
  always @(negedge bit_clock) begin
    #200;
    if ((tx_a_oe | tx_b_oe) === 1'b1) begin
      sh = {sh[6:0], tx_a_oe ? tx_a : tx_b};
      n++;
    end else if (n != 0) begin
      tx_byte = sh;
      tx_bits = n;
      n = 0;
      tx_cnt++;
    end
  end
endmodule

/* File: test_pcm_codec_digital_interface.sv */
// self-checking bench for the pcm codec digital interface
// assumes the backplane model and the design package are compiled first
`timescale 1ns/1ps
module test_pcm_codec_digital_interface;
  import pcm_codec_pkg::*;
  logic       clock = 0, rst = 1, master_reset_in = 0, arm = 0, txb = 0;
  logic       control_shift_clock = 1, chip_select_n = 1, control_serial_in = 0;
  logic       bit_clock, tx_frame_sync, rx_frame_sync, rx_pcm_in_a, rx_pcm_in_b;
  logic       tx_pcm_out_a, tx_pcm_out_a_oe, tx_pcm_out_b, tx_pcm_out_b_oe;
  logic       tx_slot_active_n_a, tx_slot_active_n_a_oe;
  logic       tx_slot_active_n_b, tx_slot_active_n_b_oe;
  logic       rx_word_valid, powered_down, control_serial_out, control_serial_out_oe;
  logic [7:0] tx_pcm_word = 0, rx_byte = 0, start = 0, rx_pcm_word, tx_byte, rd, v, ext = 0;
  logic [5:0] line_latch_i, line_latch_o, line_latch_oe;
  logic [2:0] m = 3'h0;
  logic       bidir_oe, tx_word_load;
  logic [2:0] modes[4] = '{3'h0, 3'h2, 3'h4, 3'h7};
  logic [7:0] txq[$], rxq[$];
  logic [31:0] seed = 32'hf358_c4c8;
  int         tx_bits, tx_cnt, bad_count = 0, compares = 0, loads = 0;
  always #50 clock = ~clock;
  assign rx_frame_sync = tx_frame_sync;
  assign line_latch_i = (line_latch_oe & line_latch_o) | (~line_latch_oe & ext[5:0]);
  pcm_codec_digital_interface dut (.clock, .rst, .master_reset_in, .bit_clock,
    .tx_frame_sync, .rx_frame_sync, .rx_pcm_in_a, .rx_pcm_in_b, .tx_pcm_out_a,
    .tx_pcm_out_a_oe, .tx_pcm_out_b, .tx_pcm_out_b_oe, .tx_slot_active_n_a,
    .tx_slot_active_n_a_oe, .tx_slot_active_n_b, .tx_slot_active_n_b_oe, .tx_pcm_word,
    .tx_word_load, .rx_pcm_word, .rx_word_valid, .powered_down, .control_shift_clock,
    .chip_select_n, .control_serial_in, .control_serial_out, .control_serial_out_oe,
    .control_serial_bidir_i(1'b0), .control_serial_bidir_o(), .control_serial_bidir_oe(bidir_oe),
    .line_latch_i, .line_latch_o, .line_latch_oe);
  tdm_host_model host (.arm, .rx_byte, .start, .rx_sel_b(m[2]), .bit_clock,
    .frame_sync(tx_frame_sync), .rx_a(rx_pcm_in_a), .rx_b(rx_pcm_in_b), .tx_a(tx_pcm_out_a),
    .tx_a_oe(tx_pcm_out_a_oe), .tx_b(tx_pcm_out_b), .tx_b_oe(tx_pcm_out_b_oe), .tx_byte,
    .tx_bits, .tx_cnt);
  // ===
  // helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic take(ref logic [7:0] q[$], input logic [7:0] got);
    if (q.size() == 0) chk8(got, ~got);
    else chk8(got, q.pop_front());
  endtask
  // select held, data changed while clock high
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat);
    logic [15:0] w;
    w = {ins, dat};
    chip_select_n = 0;
    for (int i = 15; i >= 0; i--) begin
      cyc(4);
      control_serial_in = w[i];
      cyc(4);
      if (i < 8) rd[i] = control_serial_out;
      if (i < 8) chk8({6'h00, bidir_oe, control_serial_out_oe},
                      {7'h00, ins[INSTR_RD_BIT]});
      control_shift_clock = 0;
      cyc(8);
      control_shift_clock = 1;
    end
    cyc(8);
    chip_select_n = 1;
    cyc(4);
  endtask
  task automatic frame(input logic [7:0] st);
    start = st;
    arm = 1;
    @(posedge tx_frame_sync);
    #5 arm = 0;
    repeat (40) @(posedge bit_clock);
    cyc(20);
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ===
  // result monitors
  // strobes read mid-cycle, clear of the edges that move them
  always @(negedge clock) if (rx_word_valid === 1'b1) take(rxq, rx_pcm_word);
  always @(negedge clock) if (tx_word_load === 1'b1) loads++;
  always @(tx_cnt) if (tx_cnt > 0) begin
    take(txq, tx_byte);
    chk8(8'(tx_bits), 8'h08);
  end
  always @(negedge bit_clock) begin
    #200;
    if ((tx_pcm_out_a_oe | tx_pcm_out_b_oe | tx_slot_active_n_a_oe | tx_slot_active_n_b_oe)
        === 1'b1)
      chk8({2'b00, tx_pcm_out_a_oe, tx_pcm_out_b_oe, tx_slot_active_n_a_oe,
            tx_slot_active_n_b_oe, tx_slot_active_n_a, tx_slot_active_n_b},
           {2'b00, ~txb, txb, ~txb, txb, 2'b00});
  end
  // ===
  // main sequence
  initial begin
    cyc(8);
    rst = 0;
    cyc(4);
    chk8({powered_down, line_latch_oe, control_serial_out_oe}, 8'h80);
    xfer({1'b0, ADDR_LATCH_DIR, 4'h0}, 8'h0f);
    v = rnd();
    xfer({1'b0, ADDR_LATCH_VAL, 4'h0}, v);
    ext = rnd();
    chk8({1'b0, powered_down, line_latch_oe}, 8'h0f);
    chk8({4'h0, line_latch_o[3:0]}, {4'h0, v[3:0]});
    xfer({1'b0, ADDR_LATCH_VAL, 4'h1}, 8'h00);
    chk8({2'b00, rd[5:0]}, {2'b00, ext[5:4], v[3:0]});
    xfer({1'b0, ADDR_TX_SLOT, 4'h0}, 8'h02);
    xfer({1'b0, ADDR_RX_SLOT, 4'h0}, 8'h02);
    // every port and timing mode; slot 2 starts at rise 17 when delayed
    foreach (modes[k]) begin
      m = modes[k];
      txb = m[MODE_TX_PORT];
      xfer({1'b0, ADDR_MODE, 4'h0}, {5'h00, m});
      tx_pcm_word = rnd();
      rx_byte = rnd();
      txq.push_back(tx_pcm_word);
      rxq.push_back(rx_byte);
      frame(m[MODE_DELAYED] ? 8'd17 : 8'd0);
    end
    // powered down: no slot either way, latch outputs kept
    xfer({1'b1, ADDR_MODE, 4'h0}, 8'h00);
    frame(8'd0);
    chk8({1'b0, powered_down, line_latch_oe}, 8'h4f);
    chk8({4'h0, line_latch_o[3:0]}, {4'h0, v[3:0]});
    chk8(8'(txq.size() + rxq.size()), 8'h00);
    // one byte load per powered-up frame, none while powered down
    chk8(8'(loads), 8'h04);
    master_reset_in = 1;
    cyc(4);
    master_reset_in = 0;
    cyc(6);
    chk8({1'b0, powered_down, line_latch_oe}, 8'h40);
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
endmodule
